// *** design/slic_port_regs.vh ***
/*
 * Constants for the slave-mode parallel control port of the subscriber line
 * interface: register offsets, field positions, reset values, mode codes and
 * timing counts.
 * Assumes it is included by bare name from the design files under design/.
 */
`ifndef SLIC_PORT_REGS_VH
`define SLIC_PORT_REGS_VH

// Wishbone register byte offsets
`define REG_STATUS 8'h00
`define REG_IRQ_STATUS 8'h04
`define REG_IRQ_MASK 8'h08
`define REG_CONTROL 8'h0c

// Status register fields
`define ST_MODE_LSB 0
`define ST_RCMD0 3
`define ST_RCMD1 4
`define ST_RING_RELAY 5
`define ST_RT_LATCHED 6
`define ST_HOOK_LOW 7
`define ST_GK_LOW 8
`define ST_THERMAL 9
`define ST_PIN_RESET 10
`define ST_SLAVE 11

// Interrupt status and mask fields
`define IRQ_W 5
`define IRQ_RING_TRIP 0
`define IRQ_HOOK_CHG 1
`define IRQ_GK_ALARM 2
`define IRQ_MODE_WR 3
`define IRQ_THERMAL 4
`define IRQ_MASK_RST 5'h00

// Control register fields
`define CTL_SYNC_EN 0
`define CTL_RST 1'h1

// Operating mode codes, written as {bit0, bit1, bit2} of the bus
`define MODE_POWER_DOWN 3'h0
`define MODE_STANDBY 3'h1
`define MODE_ACTIVE_NP 3'h2
`define MODE_ACTIVE_RP 3'h3
`define MODE_RING_NP 3'h4
`define MODE_RING_RP 3'h5
`define MODE_GROUND_START 3'h6
`define MODE_HI_IMP 3'h7

// Pin synchroniser width and idle levels (strobe, select, reset high)
`define SYNC_W 16
`define SYNC_RST_VAL 16'h00e0

// Timing: clock period and sync clock least low phase
`define CLK_PERIOD_NS 20
`define RSYNC_LOW_MIN_NS 1000
`define RSYNC_LOW_MIN_CYC ((`RSYNC_LOW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** design/pin_sync2.v ***
/*
 * Two flip-flop synchroniser for a group of asynchronous pin levels.
 * Assumes the levels change slowly against clk_i; no bus coherence is
 * promised across bits, the user qualifies data with a strobe.
 */
`timescale 1ns/1ps
module pin_sync2 #(
    parameter W = 8,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Pin levels in and synchronised out
    input wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);

    // First stage, read only by the second stage
    reg [W-1:0] meta_ff;
    // Second stage, safe to use
    reg [W-1:0] stable_ff;

    ////////////////////////////////////////////////////////////////////////
    // Two-stage capture, reset to the pins' idle levels
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= RST_VAL;
            stable_ff <= RST_VAL;
        end else begin
            meta_ff <= async_i;
            stable_ff <= meta_ff;
        end
    end

    assign sync_o = stable_ff;

endmodule

// *** design/slic_slave_control_port.v ***
/*
 * Slave-mode parallel control port of a subscriber line interface: mode and
 * relay latches, status outputs, ring-trip auto disconnect, ringing relay
 * sync and the idle states, plus a Wishbone classic register slave.
 * Assumes all pins and analog detector levels are asynchronous to clk_i and
 * that the pad logic turns the *_oe_o enables into tri-state drive.
 */
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "slic_port_regs.vh"
module slic_slave_control_port (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Control bus pins
    input wire interface_mode_i,
    input wire mode_bit_0_i,
    input wire mode_bit_1_i,
    input wire mode_bit_2_i,
    input wire test_relay_cmd_0_i,
    input wire test_relay_cmd_1_i,
    input wire input_strobe_n_i,
    input wire output_select_n_i,
    input wire reset_n_i,
    input wire ring_sync_clock_i,
    // Line detector levels from the analog core
    input wire off_hook_det_i,
    input wire ring_trip_det_i,
    input wire ground_key_det_i,
    input wire thermal_alarm_i,
    input wire line_fault_i,
    input wire ring_grounded_i,
    // Tri-state status outputs
    output reg hook_status_n_o,
    output reg hook_status_oe_o,
    output reg groundkey_alarm_n_o,
    output reg groundkey_alarm_oe_o,
    // Relay drivers
    output reg ringing_relay_drive_o,
    output reg test_relay_0_o,
    output reg test_relay_1_o,
    // Line circuit controls
    output reg line_feed_en_o,
    output reg polarity_rev_o,
    output reg ac_loop_en_o,
    output reg hook_det_en_o,
    output reg gk_det_en_o,
    // Wishbone classic slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Interrupt
    output reg irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    // Raw pins gathered, one bit each
    wire [`SYNC_W-1:0] pins_raw;
    // Synchronised copies
    wire [`SYNC_W-1:0] pins;

    assign pins_raw = {interface_mode_i, ring_grounded_i, line_fault_i,
                       thermal_alarm_i, ground_key_det_i, ring_trip_det_i,
                       off_hook_det_i, ring_sync_clock_i, reset_n_i,
                       output_select_n_i, input_strobe_n_i,
                       test_relay_cmd_1_i, test_relay_cmd_0_i,
                       mode_bit_2_i, mode_bit_1_i, mode_bit_0_i};

    pin_sync2 #(
        .W(`SYNC_W),
        .RST_VAL(`SYNC_RST_VAL)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(pins_raw),
        .sync_o(pins)
    );

    // Named views of the synchronised pins
    wire [2:0] bus_mode = {pins[0], pins[1], pins[2]};
    wire [1:0] bus_rcmd = pins[4:3];
    wire strobe_n = pins[5];
    wire select_n = pins[6];
    wire pin_reset = ~pins[7];
    wire sync_clk = pins[8];
    wire off_hook = pins[9];
    wire ring_trip = pins[10];
    wire gnd_key = pins[11];
    wire thermal = pins[12];
    wire fault = pins[13];
    wire ring_gnd = pins[14];
    wire slave = ~pins[15];

    ////////////////////////////////////////////////////////////////////////
    // State declarations

    reg [2:0] mode_ff;          // Latched operating mode
    reg [1:0] rcmd_ff;          // Latched relay commands
    reg strobe_prev_ff;         // Strobe level last cycle
    reg rt_latch_ff;            // Ring trip seen in ringing
    reg therm_prev_ff;          // Thermal level last cycle
    reg sync_en_ff;             // Ringing relay sync enable
    reg [`IRQ_W-1:0] irq_stat_ff;  // Sticky event bits
    reg [`IRQ_W-1:0] irq_mask_ff;  // Interrupt enables

    // Either reset forces the idle state
    wire idle_rst = rst_i | pin_reset;
    // Strobe rising edge, data taken here
    wire strobe_rise = strobe_n & ~strobe_prev_ff;
    // Mode in force; automatic control is not built, so it idles
    wire [2:0] eff_mode = slave ? mode_ff : `MODE_POWER_DOWN;

    wire is_pd = (eff_mode == `MODE_POWER_DOWN);
    wire is_sb = (eff_mode == `MODE_STANDBY);
    wire is_anp = (eff_mode == `MODE_ACTIVE_NP);
    wire is_arp = (eff_mode == `MODE_ACTIVE_RP);
    wire is_ring = (eff_mode == `MODE_RING_NP) | (eff_mode == `MODE_RING_RP);
    wire is_gs = (eff_mode == `MODE_GROUND_START);
    wire is_hif = (eff_mode == `MODE_HI_IMP);
    wire is_act = is_anp | is_arp;

    // ground start detectors wait for grounded ring
    wire gs_live = is_gs & ring_gnd;
    // Ring trip detected this cycle
    wire rt_set = is_ring & ring_trip & ~thermal & ~rt_latch_ff;
    // A strobe that writes a mode word, and one that writes a different mode word
    wire mode_wr = strobe_rise & slave;
    wire mode_change = mode_wr & (bus_mode != mode_ff);

    ////////////////////////////////////////////////////////////////////////
    // Mode and relay latches

    // strobe captures the bus; value at strobe rise, held after
    always @(posedge clk_i) begin
        if (idle_rst) begin
            mode_ff <= `MODE_POWER_DOWN;
            rcmd_ff <= 2'h0;
            strobe_prev_ff <= 1'b1;
        end else begin
            strobe_prev_ff <= strobe_n;
            if (strobe_rise) begin
                // Relay bits latch in either interface mode
                rcmd_ff <= bus_rcmd;
                if (slave) begin
                    mode_ff <= bus_mode;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ring trip latch and ringing relay

    // held until a different mode word is written
    always @(posedge clk_i) begin
        if (idle_rst) begin
            rt_latch_ff <= 1'b0;
        end else if (mode_change) begin
            // A new mode wins; the trip belongs to the old ringing burst
            rt_latch_ff <= 1'b0;
        end else if (rt_set) begin
            rt_latch_ff <= 1'b1;
        end
    end

    // relay on in ringing, off at ring trip without a command
    always @(posedge clk_i) begin
        if (idle_rst | thermal | ~is_ring | rt_latch_ff | rt_set) begin
            ringing_relay_drive_o <= 1'b0;
        end else if (~ringing_relay_drive_o) begin
            // turn-on only in the low phase of the sync clock
            // a clock held low lets the relay close at once
            if (~sync_en_ff | ~sync_clk) begin
                ringing_relay_drive_o <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status output values

    reg nxt_hook_n;  // Next hook status level
    reg nxt_gk_n;    // Next ground-key/alarm level

    // status meaning per mode, idle overrides first
    always @* begin
        nxt_hook_n = 1'b1;
        nxt_gk_n = 1'b1;
        if (idle_rst) begin
            nxt_hook_n = 1'b1;
            nxt_gk_n = 1'b1;
        end else if (thermal) begin
            nxt_hook_n = 1'b0;
            nxt_gk_n = 1'b0;
        end else if (is_pd) begin
            nxt_hook_n = 1'b1;
            nxt_gk_n = 1'b1;
        end else begin
            if (is_ring) begin
                nxt_hook_n = ~(rt_latch_ff | rt_set);
            end else if (is_sb | is_act | is_hif | gs_live) begin
                nxt_hook_n = ~off_hook;
            end else begin
                nxt_hook_n = 1'b1;
            end
            if (fault) begin
                nxt_gk_n = 1'b0;
            end else if (is_sb | is_act | gs_live) begin
                nxt_gk_n = ~gnd_key;
            end else begin
                nxt_gk_n = 1'b1;
            end
        end
    end

    // outputs driven only while select is low
    always @(posedge clk_i) begin
        if (rst_i) begin
            hook_status_n_o <= 1'b1;
            groundkey_alarm_n_o <= 1'b1;
            hook_status_oe_o <= 1'b0;
            groundkey_alarm_oe_o <= 1'b0;
        end else begin
            hook_status_n_o <= nxt_hook_n;
            groundkey_alarm_n_o <= nxt_gk_n;
            hook_status_oe_o <= ~select_n;
            groundkey_alarm_oe_o <= ~select_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Test relays and line circuit controls

    always @(posedge clk_i) begin
        if (idle_rst) begin
            test_relay_0_o <= 1'b0;
            test_relay_1_o <= 1'b0;
            line_feed_en_o <= 1'b0;
            polarity_rev_o <= 1'b0;
            ac_loop_en_o <= 1'b0;
            hook_det_en_o <= 1'b0;
            gk_det_en_o <= 1'b0;
        end else begin
            // relay bits steer drivers in any mode
            test_relay_0_o <= rcmd_ff[0];
            test_relay_1_o <= rcmd_ff[1];
            // ringing keeps the line circuit active
            line_feed_en_o <= ~thermal & (is_act | is_ring | is_gs);
            polarity_rev_o <= ~thermal & (is_arp | (eff_mode == `MODE_RING_RP));
            // stand-by runs without the AC loop
            ac_loop_en_o <= ~thermal & (is_act | is_ring);
            hook_det_en_o <= ~thermal & ~is_pd & (~is_gs | ring_gnd);
            gk_det_en_o <= ~thermal & (is_sb | is_act | gs_live);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone classic slave

    // Request present (cyc and stb), whether answered yet or not
    wire wb_req = wb_cyc_i & wb_stb_i;
    // Edge at which the master sees ack: writes and read-clear act here
    wire wb_done = wb_req & wb_ack_o;
    wire wb_wr = wb_done & wb_we_i & wb_sel_i[0];
    wire irq_rd = wb_done & ~wb_we_i & (wb_adr_i == `REG_IRQ_STATUS);

    // Status register image
    wire [31:0] status_word = {20'h00000, slave, pin_reset, thermal,
                               ~groundkey_alarm_n_o, ~hook_status_n_o,
                               rt_latch_ff, ringing_relay_drive_o,
                               rcmd_ff, mode_ff};

    reg [31:0] nxt_rdata;  // Read mux

    // Read data selection; unmapped reads return zero
    always @* begin
        case (wb_adr_i)
            `REG_STATUS: nxt_rdata = status_word;
            `REG_IRQ_STATUS: nxt_rdata = {27'h0000000, irq_stat_ff};
            `REG_IRQ_MASK: nxt_rdata = {27'h0000000, irq_mask_ff};
            `REG_CONTROL: nxt_rdata = {31'h00000000, sync_en_ff};
            default: nxt_rdata = 32'h00000000;
        endcase
    end

    // One wait state answer, ack dropped in the cycle after
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req & ~wb_ack_o;
            if (wb_req & ~wb_ack_o & ~wb_we_i) begin
                wb_dat_o <= nxt_rdata;
            end
        end
    end

    // Writable registers: mask and control
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_ff <= `IRQ_MASK_RST;
            sync_en_ff <= `CTL_RST;
        end else if (wb_wr) begin
            if (wb_adr_i == `REG_IRQ_MASK) begin
                irq_mask_ff <= wb_dat_i[`IRQ_W-1:0];
            end
            if (wb_adr_i == `REG_CONTROL) begin
                sync_en_ff <= wb_dat_i[`CTL_SYNC_EN];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt events

    wire [`IRQ_W-1:0] events;  // One-cycle event pulses
    wire [`IRQ_W-1:0] nxt_irq_stat;

    assign events[`IRQ_RING_TRIP] = rt_set;
    assign events[`IRQ_HOOK_CHG] = nxt_hook_n ^ hook_status_n_o;
    assign events[`IRQ_GK_ALARM] = groundkey_alarm_n_o & ~nxt_gk_n;
    assign events[`IRQ_MODE_WR] = mode_wr;
    assign events[`IRQ_THERMAL] = thermal & ~therm_prev_ff;
    // Set wins over a read-clear in the same cycle
    assign nxt_irq_stat = (irq_stat_ff & ~{`IRQ_W{irq_rd}}) | events;

    // Sticky status and level interrupt
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_ff <= {`IRQ_W{1'b0}};
            therm_prev_ff <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            therm_prev_ff <= thermal;
            irq_o <= |(nxt_irq_stat & irq_mask_ff);
        end
    end

endmodule

// *** bench/slic_port_chk.sv ***
/*
 * Checker for the slave control port: bus answer timing, status output
 * enables, ringing relay timing and the two idle states.
 * Assumes it is bound to the port's top module and sees only its ports.
 */
`timescale 1ns/1ps
module slic_port_chk (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Bus handshake
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    // Pins and detector levels
    input wire output_select_n_i,
    input wire ring_sync_clock_i,
    input wire ring_trip_det_i,
    input wire thermal_alarm_i,
    input wire reset_n_i,
    // Driven outputs
    input wire hook_status_oe_o,
    input wire groundkey_alarm_oe_o,
    input wire ringing_relay_drive_o,
    input wire test_relay_0_o,
    input wire test_relay_1_o,
    input wire hook_status_n_o,
    input wire groundkey_alarm_n_o
);
    // One domain, so clock and disable are given once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack one cycle after request");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_oe_on;
        $fell(output_select_n_i) ##1 !output_select_n_i [*3] |-> hook_status_oe_o && groundkey_alarm_oe_o;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("status not driven while selected");
    property p_oe_off;
        output_select_n_i [*4] |-> !hook_status_oe_o && !groundkey_alarm_oe_o;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("status driven while deselected");
    property p_relay_sync;
        $rose(ringing_relay_drive_o) |-> !$past(ring_sync_clock_i, 2) || !$past(ring_sync_clock_i, 3)
            || !$past(ring_sync_clock_i, 4);
    endproperty
    a_relay_sync: assert property (p_relay_sync) else $error("ring relay on in sync high phase");
    property p_ring_trip;
        ring_trip_det_i [*4] |-> !ringing_relay_drive_o;
    endproperty
    a_ring_trip: assert property (p_ring_trip) else $error("ring relay on during ring trip");
    property p_reset_idle;
        !reset_n_i [*5] |-> !test_relay_0_o && !test_relay_1_o && !ringing_relay_drive_o
            && hook_status_n_o && groundkey_alarm_n_o;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("outputs active in reset idle");
    property p_thermal;
        (thermal_alarm_i && reset_n_i) [*5] |-> !hook_status_n_o && !groundkey_alarm_n_o && !ringing_relay_drive_o;
    endproperty
    a_thermal: assert property (p_thermal) else $error("status not low in thermal idle");
endmodule
bind slic_slave_control_port slic_port_chk i_chk (.*);

// *** bench/line_card_model.sv ***
/*
 * Line card controller model: drives the control bus, strobe, select,
 * device reset pin and the ringing-rate clock.
 * Assumes the bench calls its tasks between clock edges it waits for.
 */
`timescale 1ns/1ps
module line_card_model (
    // Clock
    input wire clk_i,
    // Control bus pins
    output logic mode_bit_0_o = 1'h0,
    output logic mode_bit_1_o = 1'h0,
    output logic mode_bit_2_o = 1'h0,
    output logic test_relay_cmd_0_o = 1'h0,
    output logic test_relay_cmd_1_o = 1'h0,
    output logic input_strobe_n_o = 1'h1,
    output logic output_select_n_o = 1'h1,
    output logic reset_n_o = 1'h1,
    output logic ring_sync_clock_o = 1'h0
);
    logic ring_run = 1'h0; // Ringing clock enable, set by bench
    int phase = 0; // Position in a 100-cycle ring period
    ////////////////////////////////////////
    // low phase 60 cycles, idle low
    always @(posedge clk_i) begin
        phase <= (phase == 99) ? 0 : phase + 1;
        ring_sync_clock_o <= ring_run && (phase >= 60);
    end
    // Select and reset pin levels
    task automatic set_lines(input logic sel_n, input logic rst_n);
        @(posedge clk_i);
        output_select_n_o <= sel_n;
        reset_n_o <= rst_n;
    endtask
    task automatic write_word(input logic [2:0] code, input logic [1:0] rcmd);
        @(posedge clk_i);
        {mode_bit_0_o, mode_bit_1_o, mode_bit_2_o} <= code;
        {test_relay_cmd_1_o, test_relay_cmd_0_o} <= rcmd;
        input_strobe_n_o <= 1'h0;
        repeat (4) @(posedge clk_i);
        input_strobe_n_o <= 1'h1;
        repeat (4) @(posedge clk_i);
        // Released lines sink to the pull-down level
        {mode_bit_0_o, mode_bit_1_o, mode_bit_2_o, test_relay_cmd_1_o, test_relay_cmd_0_o} <= 5'h00;
        repeat (3) @(posedge clk_i);
    endtask
endmodule

// *** bench/slic_slave_control_port_bench.sv ***
/*
 * Bench for the slave control port: the line card model drives the pins,
 * Wishbone tasks reach the registers, a mode table predicts the line control and status outputs.
 * Assumes the design and its header are compiled from design/.
 */
`timescale 1ns/1ps
`include "slic_port_regs.vh"
module slic_slave_control_port_bench;
    // Clock, reset, mode pin starting in slave
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic interface_mode_i = 1'h0;
    // Detector levels and bus
    logic off_hook_det_i = 1'h0, ring_trip_det_i = 1'h0, ground_key_det_i = 1'h0;
    logic thermal_alarm_i = 1'h0, line_fault_i = 1'h0, ring_grounded_i = 1'h1;
    logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    // Pins from the model, design outputs
    wire mode_bit_0_i, mode_bit_1_i, mode_bit_2_i, test_relay_cmd_0_i, test_relay_cmd_1_i;
    wire input_strobe_n_i, output_select_n_i, reset_n_i, ring_sync_clock_i;
    wire hook_status_n_o, hook_status_oe_o, groundkey_alarm_n_o, groundkey_alarm_oe_o;
    wire ringing_relay_drive_o, test_relay_0_o, test_relay_1_o, irq_o, wb_ack_o;
    wire line_feed_en_o, polarity_rev_o, ac_loop_en_o, hook_det_en_o, gk_det_en_o;
    wire [31:0] wb_dat_o;
    // Reference model: written modes and per-mode tables
    int failures = 0;
    int n_checks = 0;
    int mode_q[$];
    logic [4:0] exp_line [8] = '{5'h00, 5'h03, 5'h17, 5'h1f, 5'h16, 5'h1e, 5'h13, 5'h02};
    logic [7:0] hk_mode = 8'hce; // Modes where hook reports off-hook
    logic [7:0] gk_mode = 8'h4e; // Modes where ground-key reports
    ////////////////////////////////////////
    always #10 clk_i = ~clk_i;
    slic_slave_control_port i_dut (.*);
    line_card_model i_lc (.clk_i(clk_i), .mode_bit_0_o(mode_bit_0_i), .mode_bit_1_o(mode_bit_1_i),
        .mode_bit_2_o(mode_bit_2_i), .test_relay_cmd_0_o(test_relay_cmd_0_i),
        .test_relay_cmd_1_o(test_relay_cmd_1_i), .input_strobe_n_o(input_strobe_n_i),
        .output_select_n_o(output_select_n_i), .reset_n_o(reset_n_i), .ring_sync_clock_o(ring_sync_clock_i));
    ////////////////////////////////////////
    // Compare pin groups
    task automatic chk_pin(input string what, input logic [4:0] exp, input logic [4:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Compare register words
    task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One classic cycle, held until ack is sampled
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, adr, dat};
        // No answer time assumed; only the watchdog ends a hung wait
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'h1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] msk, input logic [31:0] exp);
        logic [31:0] rd;
        wb_cycle(1'h0, adr, 32'h0, rd);
        chk_reg(what, exp, rd & msk);
    endtask
    // Let edge updates land before looking
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic summarize;
        if (failures == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        repeat (40000) @(posedge clk_i);
        failures++;
        summarize();
    end
    ////////////////////////////////////////
    initial begin
        logic [31:0] rd;
        logic [1:0] rc;
        logic oh, gk;
        int n;
        void'($urandom(32'hd61828b1));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        rd_chk("irq_mask", `REG_IRQ_MASK, 32'h1f, 32'h0);
        rd_chk("control", `REG_CONTROL, 32'h1, 32'h1);
        rd_chk("unmapped", 8'h40, 32'hffffffff, 32'h0);
        wb_cycle(1'h1, `REG_IRQ_MASK, 32'h8, rd);
        wb_cycle(1'h1, `REG_CONTROL, 32'h1, rd);
        i_lc.set_lines(1'h0, 1'h1);
        // Every mode code with random relays and detectors
        for (int code = 0; code < 8; code++) begin
            rc = $urandom;
            oh = $urandom;
            gk = $urandom;
            @(posedge clk_i);
            off_hook_det_i <= oh;
            ground_key_det_i <= gk;
            i_lc.write_word(code[2:0], rc);
            mode_q.push_back(code);
            settle(3);
            chk_pin("line", exp_line[code], {line_feed_en_o, polarity_rev_o, ac_loop_en_o, hook_det_en_o, gk_det_en_o});
            chk_pin("relay", 5'(rc), 5'({test_relay_1_o, test_relay_0_o}));
            chk_pin("status", 5'({~(hk_mode[code] & oh), ~(gk_mode[code] & gk)}),
                5'({hook_status_n_o, groundkey_alarm_n_o}));
            chk_pin("oe", 5'h3, 5'({hook_status_oe_o, groundkey_alarm_oe_o}));
            rd_chk("status_mode", `REG_STATUS, 32'h7, mode_q[$]);
        end
        // Mode strobe event, masked in, cleared by read
        chk_pin("irq_set", 5'h1, 5'(irq_o));
        rd_chk("irq_status", `REG_IRQ_STATUS, 32'h8, 32'h8);
        settle(2);
        chk_pin("irq_clear", 5'h0, 5'(irq_o));
        rd_chk("irq_status_clr", `REG_IRQ_STATUS, 32'h8, 32'h0);
        // Ground start with the ring wire floating
        @(posedge clk_i) ring_grounded_i <= 1'h0;
        off_hook_det_i <= 1'h1;
        i_lc.write_word(3'h6, 2'h0);
        settle(3);
        chk_pin("gs_float", 5'h10, {line_feed_en_o, polarity_rev_o, ac_loop_en_o, hook_det_en_o, gk_det_en_o});
        // Ringing, trip, latched hook low
        @(posedge clk_i) off_hook_det_i <= 1'h0;
        i_lc.ring_run <= 1'h1;
        i_lc.write_word(3'h4, 2'h0);
        n = 0;
        while (ringing_relay_drive_o !== 1'h1 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        chk_pin("ring_relay", 5'h1, 5'(ringing_relay_drive_o));
        @(posedge clk_i) ring_trip_det_i <= 1'h1;
        settle(6);
        chk_pin("trip", 5'h0, 5'({ringing_relay_drive_o, hook_status_n_o}));
        @(posedge clk_i) ring_trip_det_i <= 1'h0;
        i_lc.write_word(3'h4, 2'h0);
        settle(3);
        chk_pin("trip_held", 5'h0, 5'(hook_status_n_o));
        @(posedge clk_i) i_lc.ring_run <= 1'h0;
        i_lc.write_word(3'h2, 2'h0);
        settle(3);
        chk_pin("trip_freed", 5'h1, 5'(hook_status_n_o));
        // Line fault, then thermal idle with relays on
        @(posedge clk_i) line_fault_i <= 1'h1;
        ground_key_det_i <= 1'h0;
        settle(5);
        chk_pin("fault", 5'h0, 5'(groundkey_alarm_n_o));
        @(posedge clk_i) line_fault_i <= 1'h0;
        thermal_alarm_i <= 1'h1;
        i_lc.write_word(3'h2, 2'h3);
        settle(3);
        chk_pin("thermal", 5'h0c, 5'({test_relay_1_o, test_relay_0_o, hook_status_n_o, groundkey_alarm_n_o}));
        @(posedge clk_i) thermal_alarm_i <= 1'h0;
        // Reset pin idle, latches back to power down
        i_lc.set_lines(1'h0, 1'h0);
        settle(6);
        chk_pin("reset_idle", 5'h3, 5'({test_relay_1_o, test_relay_0_o, hook_status_n_o, groundkey_alarm_n_o}));
        i_lc.set_lines(1'h0, 1'h1);
        settle(4);
        chk_pin("reset_mode", 5'h00, {line_feed_en_o, polarity_rev_o, ac_loop_en_o, hook_det_en_o, gk_det_en_o});
        // Mode pin high: mode word ignored, relay bits still latch
        @(posedge clk_i) interface_mode_i <= 1'h1;
        i_lc.write_word(3'h3, 2'h2);
        settle(3);
        chk_pin("auto_mode", 5'h00, {line_feed_en_o, polarity_rev_o, ac_loop_en_o, hook_det_en_o, gk_det_en_o});
        chk_pin("auto_relay", 5'h2, 5'({test_relay_1_o, test_relay_0_o}));
        @(posedge clk_i) interface_mode_i <= 1'h0;
        i_lc.set_lines(1'h1, 1'h1);
        settle(5);
        chk_pin("oe_off", 5'h0, 5'({hook_status_oe_o, groundkey_alarm_oe_o}));
        summarize();
    end
endmodule
